/* File: logic/regc_pkg.sv */
/*
  Constants, types and helpers for the first step-down rail enable gate.
  Assumes a 10 MHz system clock and three configuration bytes mirrored
  from one-time-programmable memory at power-up.
*/
// Functional notes
// - Mask bit zero includes that rail's power-good; one excludes it.
// - Mask bits 7,6,5 gate linear_reg_3, linear_reg_2, load_switch_a.
// - Mask bits 4..0 gate step_down_rail_6 down to step_down_rail_2.
// - Pin-select bits 1,0 mask shared b2/linear_reg_1 and load_switch_b1.
// - Source codes 000-100 and 110 pick inputs 1,2,5,4,3,6.
// - Source code 111 inserts constant one; no pin needed.
// - Pin-select bit 5 picks 10 mV (0) or 25 mV (1) steps.
// - Bits 5:3 code the falling delay: 0,2,4,8,16,24,32,64 ms.
// - Bits 2:0 code the rising delay with the same table.
// - Delays may be off by ten percent; coarse time base is fine.
// - Registers load from OTP contents at reset.
// - Registers answer at I2C address 0x38 only in programming mode.
package regc_pkg;

    // Register offsets
    localparam logic [7:0] OFF_POWER_GOOD_FLAG_MASK = 8'h07;
    localparam logic [7:0] OFF_PIN_STEP = 8'h08;
    localparam logic [7:0] OFF_EDGE_DELAYS = 8'h09;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int STEP_BIT = 5;
    localparam int SEL_HI = 4;
    localparam int SEL_LO = 2;
    localparam int OFF_DLY_HI = 5;
    localparam int OFF_DLY_LO = 3;
    localparam int ON_DLY_HI = 2;
    localparam int ON_DLY_LO = 0;

    // Serial port
    localparam logic [6:0] I2C_ADDR = 7'h38;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

    // Power-good flags in mask bit order
    typedef struct packed {
        logic linear_reg_3;
        logic linear_reg_2;
        logic load_switch_a;
        logic step_down_rail_6;
        logic step_down_rail_5;
        logic step_down_rail_4;
        logic step_down_rail_3;
        logic step_down_rail_2;
        logic shared_b2_linear_1;
        logic load_switch_b1;
    } regc_power_good_flag_t;

    // Configuration image
    typedef struct packed {
        logic [7:0] power_good_flag_mask;
        logic [7:0] pin_step;
        logic [7:0] edge_delays;
    } regc_cfg_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK_AW = 4'h2,
        ST_ACK_AR = 4'h3,
        ST_PTR = 4'h4,
        ST_ACK_PTR = 4'h5,
        ST_WDATA = 4'h6,
        ST_ACK_DATA = 4'h7,
        ST_RDATA = 4'h8,
        ST_RACK = 4'h9,
        ST_RNEXT = 4'ha
    } regc_i2c_state_t;

    typedef enum logic [1:0] {
        RS_OFF = 2'h0,
        RS_WAIT_ON = 2'h1,
        RS_ON = 2'h2,
        RS_WAIT_OFF = 2'h3
    } regc_rail_state_t;

    // Delay code to milliseconds
    function automatic logic [6:0] delay_ms(input logic [2:0] code);
        case (code)
            3'h0: delay_ms = 7'h00;
            3'h1: delay_ms = 7'h02;
            3'h2: delay_ms = 7'h04;
            3'h3: delay_ms = 7'h08;
            3'h4: delay_ms = 7'h10;
            3'h5: delay_ms = 7'h18;
            3'h6: delay_ms = 7'h20;
            default: delay_ms = 7'h40;
        endcase
    endfunction

endpackage

/* File: logic/regc_edge_delay.sv */
/*
  Rail on/off sequencer with coded rising and falling delays.
  Assumes the enable condition is synchronous to the system clock.
*/
module regc_edge_delay #(
    parameter int TICK_CYCLES = regc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Condition and delay codes
    input wire logic cond_i,
    input wire logic [2:0] on_code_i,
    input wire logic [2:0] off_code_i,
    // Rail enable
    output logic rail_en_o
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    regc_pkg::regc_rail_state_t state;
    logic [TW-1:0] tick_cnt;
    logic [6:0] ms_cnt;
    logic [6:0] on_ms;
    logic [6:0] off_ms;
    logic [6:0] target_ms;
    logic done;

    // Decoded delays and expiry
    assign on_ms = regc_pkg::delay_ms(on_code_i);
    assign off_ms = regc_pkg::delay_ms(off_code_i);
    assign target_ms = (state == regc_pkg::RS_WAIT_ON) ? on_ms : off_ms;
    // Reached or passed, so a code lowered during a wait cannot run the count past it
    assign done = (ms_cnt >= target_ms);
    assign rail_en_o = (state == regc_pkg::RS_ON) || (state == regc_pkg::RS_WAIT_OFF);

    // Sequencer and millisecond tick counter
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= regc_pkg::RS_OFF;
            tick_cnt <= '0;
            ms_cnt <= 7'h00;
        end
        else
        begin
            unique case (state)
                regc_pkg::RS_OFF:
                begin
                    tick_cnt <= '0;
                    ms_cnt <= 7'h00;
                    if (cond_i)
                        state <= (on_ms == 7'h00) ? regc_pkg::RS_ON : regc_pkg::RS_WAIT_ON;
                end
                regc_pkg::RS_ON:
                begin
                    tick_cnt <= '0;
                    ms_cnt <= 7'h00;
                    if (!cond_i)
                        state <= (off_ms == 7'h00) ? regc_pkg::RS_OFF : regc_pkg::RS_WAIT_OFF;
                end
                regc_pkg::RS_WAIT_ON, regc_pkg::RS_WAIT_OFF:
                begin
                    if (cond_i != (state == regc_pkg::RS_WAIT_ON))
                        state <= (state == regc_pkg::RS_WAIT_ON) ? regc_pkg::RS_OFF : regc_pkg::RS_ON;
                    else if (done)
                        state <= (state == regc_pkg::RS_WAIT_ON) ? regc_pkg::RS_ON : regc_pkg::RS_OFF;
                    else if (tick_cnt == TICK_LAST)
                    begin
                        tick_cnt <= '0;
                        ms_cnt <= ms_cnt + 7'h01;
                    end
                    else
                        tick_cnt <= tick_cnt + TW'(1);
                end
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_zero_on_delay: assert property (
        (state == regc_pkg::RS_OFF && cond_i && on_code_i == 3'h0) |=> rail_en_o)
        else $error("rail not enabled at once with zero rising delay");
    a_off_delay_hold: assert property (
        (state == regc_pkg::RS_ON && !cond_i && off_code_i != 3'h0) |=> rail_en_o [*2])
        else $error("rail dropped before falling delay");
    a_tick_bound: assert property (tick_cnt <= TICK_LAST && ms_cnt <= 7'h40)
        else $error("delay counters out of range");
    a_rise_cause: assert property ($rose(rail_en_o) |-> $past(cond_i))
        else $error("rail enabled without condition");

    c_delayed_on: cover property (state == regc_pkg::RS_WAIT_ON ##1 state == regc_pkg::RS_ON);
    c_delayed_off: cover property (state == regc_pkg::RS_WAIT_OFF ##1 state == regc_pkg::RS_OFF);

endmodule // regc_edge_delay

/* File: logic/regc_rail_gate.sv */
/*
  Enable gate for the first step-down rail: pin source select, power-good
  masking, coded edge delays, step size, and an I2C register slave.
  Assumes SCL/SDA and all pins are synchronous to the 10 MHz clock, SDA is
  open drain with an external pull-up, and OTP image is valid at reset.
*/
module regc_rail_gate #(
    parameter int TICK_CYCLES = regc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    // I2C pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // Mode and OTP image
    input wire logic PROG_MODE_I,
    input wire regc_pkg::regc_cfg_t OTP_IMAGE_I,
    // Enable inputs, bit k is enable_input_(k+1)
    input wire logic [5:0] ENABLE_INPUTS_I,
    input wire regc_pkg::regc_power_good_flag_t POWER_GOOD_FLAG_I,
    // Rail controls
    output logic RAIL_EN_O,
    output logic STEP_25MV_O
);
    regc_pkg::regc_cfg_t cfg;
    regc_pkg::regc_i2c_state_t state;
    logic otp_pending;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [7:0] rd_byte;
    logic sda_pull;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [2:0] src_sel;
    logic en_req;
    logic pg_ok;
    logic step_q;

    // Register read mux, unmapped offsets read zero
    function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                            input regc_pkg::regc_cfg_t c);
        case (addr)
            regc_pkg::OFF_POWER_GOOD_FLAG_MASK: read_reg = c.power_good_flag_mask;
            regc_pkg::OFF_PIN_STEP: read_reg = c.pin_step;
            regc_pkg::OFF_EDGE_DELAYS: read_reg = c.edge_delays;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // Enable source multiplexer
    function automatic logic pick_source(input logic [2:0] sel,
                                         input logic [5:0] pins);
        unique case (sel)
            3'h0: pick_source = pins[0];
            3'h1: pick_source = pins[1];
            3'h2: pick_source = pins[4];
            3'h3: pick_source = pins[3];
            3'h4: pick_source = pins[2];
            3'h5: pick_source = pins[2] & pins[3];
            3'h6: pick_source = pins[5];
            3'h7: pick_source = 1'b1;
        endcase
    endfunction

    // Enable condition
    assign src_sel = cfg.pin_step[regc_pkg::SEL_HI:regc_pkg::SEL_LO];
    assign en_req = pick_source(src_sel, ENABLE_INPUTS_I);
    assign pg_ok = &(POWER_GOOD_FLAG_I | {cfg.power_good_flag_mask, cfg.pin_step[1:0]});
    assign rd_byte = read_reg(ptr, cfg);

    // Open-drain data line
    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_pull;

    // Bus line history
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= SCL_I;
            sda_q <= SDA_I;
        end
    end

    // Bus events
    assign scl_rise = SCL_I & ~scl_q;
    assign scl_fall = ~SCL_I & scl_q;
    assign start_seen = SCL_I & scl_q & sda_q & ~SDA_I;
    assign stop_seen = SCL_I & scl_q & ~sda_q & SDA_I;

    // I2C slave engine
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state <= regc_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            sda_pull <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end
        else
        begin
            wr_en <= 1'b0;
            if (start_seen)
            begin
                state <= regc_pkg::ST_ADDR;
                bit_cnt <= 4'h0;
                sda_pull <= 1'b0;
            end
            else if (stop_seen)
            begin
                state <= regc_pkg::ST_IDLE;
                sda_pull <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (state)
                    regc_pkg::ST_ADDR, regc_pkg::ST_PTR, regc_pkg::ST_WDATA:
                    begin
                        shift <= {shift[6:0], SDA_I};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    regc_pkg::ST_RDATA:
                        bit_cnt <= bit_cnt + 4'h1;
                    regc_pkg::ST_RACK:
                    begin
                        if (SDA_I)
                            state <= regc_pkg::ST_IDLE;
                        else
                        begin
                            ptr <= ptr + 8'h01;
                            state <= regc_pkg::ST_RNEXT;
                        end
                    end
                    default:
                        bit_cnt <= bit_cnt;
                endcase
            end
            else if (scl_fall)
            begin
                case (state)
                    regc_pkg::ST_ADDR:
                    begin
                        if (bit_cnt == regc_pkg::BYTE_BITS)
                        begin
                            if (shift[7:1] == regc_pkg::I2C_ADDR && PROG_MODE_I)
                            begin
                                sda_pull <= 1'b1;
                                state <= shift[0] ? regc_pkg::ST_ACK_AR : regc_pkg::ST_ACK_AW;
                            end
                            else
                                state <= regc_pkg::ST_IDLE;
                        end
                    end
                    regc_pkg::ST_PTR:
                    begin
                        if (bit_cnt == regc_pkg::BYTE_BITS)
                        begin
                            ptr <= shift;
                            sda_pull <= 1'b1;
                            state <= regc_pkg::ST_ACK_PTR;
                        end
                    end
                    regc_pkg::ST_WDATA:
                    begin
                        if (bit_cnt == regc_pkg::BYTE_BITS)
                        begin
                            wr_en <= 1'b1;
                            wr_addr <= ptr;
                            wr_data <= shift;
                            ptr <= ptr + 8'h01;
                            sda_pull <= 1'b1;
                            state <= regc_pkg::ST_ACK_DATA;
                        end
                    end
                    regc_pkg::ST_ACK_AW:
                    begin
                        sda_pull <= 1'b0;
                        bit_cnt <= 4'h0;
                        state <= regc_pkg::ST_PTR;
                    end
                    regc_pkg::ST_ACK_PTR, regc_pkg::ST_ACK_DATA:
                    begin
                        sda_pull <= 1'b0;
                        bit_cnt <= 4'h0;
                        state <= regc_pkg::ST_WDATA;
                    end
                    regc_pkg::ST_ACK_AR, regc_pkg::ST_RNEXT:
                    begin
                        tx <= rd_byte;
                        sda_pull <= ~rd_byte[7];
                        bit_cnt <= 4'h0;
                        state <= regc_pkg::ST_RDATA;
                    end
                    regc_pkg::ST_RDATA:
                    begin
                        if (bit_cnt == regc_pkg::BYTE_BITS)
                        begin
                            sda_pull <= 1'b0;
                            state <= regc_pkg::ST_RACK;
                        end
                        else
                        begin
                            tx <= {tx[6:0], 1'b0};
                            sda_pull <= ~tx[6];
                        end
                    end
                    default:
                        sda_pull <= 1'b0;
                endcase
            end
        end
    end

    // Configuration registers, OTP image taken just after reset release
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            cfg <= {regc_pkg::REG_RESET, regc_pkg::REG_RESET, regc_pkg::REG_RESET};
            otp_pending <= 1'b1;
        end
        else if (otp_pending)
        begin
            cfg <= OTP_IMAGE_I;
            otp_pending <= 1'b0;
        end
        else if (wr_en)
        begin
            case (wr_addr)
                regc_pkg::OFF_POWER_GOOD_FLAG_MASK: cfg.power_good_flag_mask <= wr_data;
                regc_pkg::OFF_PIN_STEP: cfg.pin_step <= wr_data;
                regc_pkg::OFF_EDGE_DELAYS: cfg.edge_delays <= wr_data;
                default: cfg <= cfg;
            endcase
        end
    end

    // Step size output
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            step_q <= 1'b0;
        else
            step_q <= cfg.pin_step[regc_pkg::STEP_BIT];
    end
    assign STEP_25MV_O = step_q;

    // Delay sequencer
    regc_edge_delay #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_delay (
        .clk_i(SYS_CLK_I),
        .arst_n_i(ARST_N_I),
        .cond_i(en_req & pg_ok & ~otp_pending),
        .on_code_i(cfg.edge_delays[regc_pkg::ON_DLY_HI:regc_pkg::ON_DLY_LO]),
        .off_code_i(cfg.edge_delays[regc_pkg::OFF_DLY_HI:regc_pkg::OFF_DLY_LO]),
        .rail_en_o(RAIL_EN_O)
    );

    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    a_power_good_flag_map: assert property (
        pg_ok == ((POWER_GOOD_FLAG_I.linear_reg_3 | cfg.power_good_flag_mask[7])
                & (POWER_GOOD_FLAG_I.linear_reg_2 | cfg.power_good_flag_mask[6])
                & (POWER_GOOD_FLAG_I.load_switch_a | cfg.power_good_flag_mask[5])
                & (POWER_GOOD_FLAG_I.step_down_rail_6 | cfg.power_good_flag_mask[4])
                & (POWER_GOOD_FLAG_I.step_down_rail_2 | cfg.power_good_flag_mask[0])
                & (POWER_GOOD_FLAG_I.shared_b2_linear_1 | cfg.pin_step[1])
                & (POWER_GOOD_FLAG_I.load_switch_b1 | cfg.pin_step[0])
                & (&(POWER_GOOD_FLAG_I[5:3] | cfg.power_good_flag_mask[3:1]))))
        else $error("power-good mask mapping wrong");
    a_unmasked_blocks: assert property (
        (!RAIL_EN_O && !POWER_GOOD_FLAG_I.step_down_rail_3 && !cfg.power_good_flag_mask[1]) |=> !RAIL_EN_O)
        else $error("rail enabled with unmasked bad power-good");
    a_source_pick: assert property (
        (src_sel == 3'h2) |-> (en_req == ENABLE_INPUTS_I[4]))
        else $error("code 010 not routed to enable_input_5");
    a_source_both: assert property (
        (src_sel == 3'h5) |-> (en_req == (ENABLE_INPUTS_I[2] & ENABLE_INPUTS_I[3])))
        else $error("code 101 not both inputs");
    a_source_const: assert property ((src_sel == 3'h7) |-> en_req)
        else $error("code 111 not constant one");
    a_step_follow: assert property (
        $changed(cfg.pin_step[5]) |=> (STEP_25MV_O == $past(cfg.pin_step[5])))
        else $error("step size output lags");
    a_otp_load: assert property (otp_pending |=> (cfg == $past(OTP_IMAGE_I)))
        else $error("OTP image not loaded");
    a_ack_in_prog: assert property (
        (state == regc_pkg::ST_ADDR && scl_fall && bit_cnt == regc_pkg::BYTE_BITS
            && !PROG_MODE_I) |=> !sda_pull)
        else $error("address acked outside programming mode");

    c_reg_write: cover property (wr_en && wr_addr == regc_pkg::OFF_EDGE_DELAYS);
    c_reg_read: cover property (state == regc_pkg::ST_RACK);
    c_rail_on: cover property ($rose(RAIL_EN_O));

endmodule // regc_rail_gate

/* File: sim/regc_rail_gate_tb_top.sv */
/*
  Self-checking bench for the first step-down rail enable gate.
  Assumes the design runs with a ten-cycle millisecond tick and an SDA pull-up.
*/
module regc_rail_gate_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl = 1'b1;
    logic sda_d = 1'b1;
    logic prog = 1'b1;
    logic [5:0] pins = 6'h00;
    regc_pkg::regc_power_good_flag_t pg = 10'h3ff;
    regc_pkg::regc_cfg_t otp = 24'h000000;
    logic sda_oe;
    logic sda_o;
    logic rail_en;
    logic step25;
    // Open-drain data line with pull-up
    wire logic sda = sda_d & (sda_oe ? sda_o : 1'b1);
    int seed = 32'h88cf;
    int bad_count = 0;
    int checked = 0;
    int t_ms[8] = '{0, 2, 4, 8, 16, 24, 32, 64};

    // Clock
    always #50 clk = ~clk;

    regc_rail_gate #(.TICK_CYCLES(TK)) i_dut (
        .SYS_CLK_I(clk), .ARST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_O(sda_oe), .PROG_MODE_I(prog), .OTP_IMAGE_I(otp),
        .ENABLE_INPUTS_I(pins), .POWER_GOOD_FLAG_I(pg), .RAIL_EN_O(rail_en), .STEP_25MV_O(step25)
    );

    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Value comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Delay comparison, coarse time base allowed ten percent slack
    task automatic chk_dly(input int n, input int ms, input string what);
        checked++;
        if (n < ms * TK || n > ms * TK + ms * TK / 10 + 3)
        begin
            bad_count++;
            $display("Error at %0t: %s took %0d cycles for %0d ms", $time, what, n, ms);
        end
    endtask

    // Expected rail enable from configuration, pins and flags
    function automatic logic exp_en(regc_pkg::regc_cfg_t c, logic [5:0] p, logic [9:0] g);
        logic src;
        case (c.pin_step[4:2])
            3'h0: src = p[0];
            3'h1: src = p[1];
            3'h2: src = p[4];
            3'h3: src = p[3];
            3'h4: src = p[2];
            3'h5: src = p[2] & p[3];
            3'h6: src = p[5];
            default: src = 1'b1;
        endcase
        return src & (&(g | {c.power_good_flag_mask, c.pin_step[1:0]}));
    endfunction

    // Reload the image through reset
    task automatic load_otp(input regc_pkg::regc_cfg_t c);
        otp = c;
        rst_n = 1'b0;
        w(3);
        rst_n = 1'b1;
        w(3);
        chk({7'h00, step25}, {7'h00, c.pin_step[5]}, "step size");
    endtask

    // One serial line step, one signal changed at a time
    task automatic step(input logic c, input logic d);
        scl = c;
        sda_d = d;
        w(3);
    endtask

    task automatic i2c_start();
        step(1'b0, sda_d);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask

    task automatic i2c_stop();
        step(1'b0, sda_d);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask

    // Eight bits MSB first plus the acknowledge slot
    task automatic bit9(input logic [8:0] o, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            step(1'b0, sda_d);
            step(1'b0, o[i]);
            step(1'b1, o[i]);
            r[i] = sda;
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, input logic ack);
        logic [8:0] r;
        i2c_start();
        bit9({regc_pkg::I2C_ADDR, 2'b01}, r);
        chk({7'h00, r[0]}, {7'h00, ~ack}, "address ack");
        if (ack)
        begin
            bit9({a, 1'b1}, r);
            bit9({d, 1'b1}, r);
        end
        i2c_stop();
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        logic [8:0] r;
        i2c_start();
        bit9({regc_pkg::I2C_ADDR, 2'b01}, r);
        bit9({a, 1'b1}, r);
        i2c_start();
        bit9({regc_pkg::I2C_ADDR, 2'b11}, r);
        bit9(9'h1ff, r);
        d = r[8:1];
        i2c_stop();
    endtask

    // Wait for the rail to reach a level, counting cycles
    task automatic wait_en(input logic v, output int n);
        n = 0;
        do
        begin
            w(1);
            n++;
        end
        while (rail_en !== v && n < 1000);
    endtask

    // Main sequence
    initial
    begin
        regc_pkg::regc_cfg_t c;
        logic [7:0] d;
        int n;
        c = 24'($random(seed));
        load_otp(c);
        for (int i = 0; i < 3; i++)
        begin
            reg_rd(regc_pkg::OFF_POWER_GOOD_FLAG_MASK + 8'(i), d);
            chk(d, c[23 - 8 * i -: 8], "image readback");
        end
        // Step size is left to the OTP image; only the source field is rewritten
        reg_wr(regc_pkg::OFF_PIN_STEP, c.pin_step ^ 8'h1c, 1'b1);
        w(3);
        chk({7'h00, step25}, {7'h00, c.pin_step[5]}, "step after write");
        reg_rd(regc_pkg::OFF_PIN_STEP, d);
        chk(d, c.pin_step ^ 8'h1c, "select written");
        d = 8'($random(seed));
        reg_wr(regc_pkg::OFF_POWER_GOOD_FLAG_MASK, d, 1'b1);
        // Outside programming mode the address is not answered
        prog = 1'b0;
        reg_wr(regc_pkg::OFF_POWER_GOOD_FLAG_MASK, ~d, 1'b0);
        prog = 1'b1;
        reg_rd(regc_pkg::OFF_POWER_GOOD_FLAG_MASK, c.power_good_flag_mask);
        chk(c.power_good_flag_mask, d, "mask kept");
        reg_wr(8'h0a, 8'h5a, 1'b1);
        reg_rd(8'h0a, d);
        chk(d, 8'h00, "unmapped read");
        // Every source code with random masks, pins and flags
        for (int s = 0; s < 8; s++)
        begin
            c = 24'($random(seed));
            c.pin_step[4:2] = 3'(s);
            c.edge_delays = 8'h00;
            load_otp(c);
            repeat (10)
            begin
                pins = 6'($random(seed));
                pg = ($random(seed) & 1) ? 10'h3ff : 10'($random(seed));
                w(4);
                chk({7'h00, rail_en}, {7'h00, exp_en(c, pins, pg)}, "rail enable");
            end
        end
        // Every rising and falling delay code
        pg = 10'h3ff;
        for (int k = 0; k < 8; k++)
        begin
            c = {8'hff, 8'h03, 2'b00, 3'(7 - k), 3'(k)};
            pins = 6'h00;
            load_otp(c);
            pins[0] = 1'b1;
            wait_en(1'b1, n);
            chk_dly(n, t_ms[k], "rising delay");
            pins[0] = 1'b0;
            wait_en(1'b0, n);
            chk_dly(n, t_ms[7 - k], "falling delay");
        end
        // A request withdrawn during its wait never reaches the rail; the long
        // falling delay would keep a wrongly completed rise visible at the check
        c.edge_delays = 8'h3b;
        load_otp(c);
        pins[0] = 1'b1;
        w(40);
        pins[0] = 1'b0;
        w(100);
        chk({7'h00, rail_en}, 8'h00, "cancelled rise");
        end_of_test();
    end

    // Watchdog
    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule // regc_rail_gate_tb_top
